// >>> include/tcp_pkg.sv
// constants for the tdm configurable-port register bank
package tcp_pkg;
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam int POS_W = 11;
	localparam int SLOT_LOG2 = 3;
	localparam int NUM_LINES = 8;
	localparam int LOW_LINES = 4;

	localparam logic [7:0] OFS_MODE_ONE = 8'h2c;
	localparam logic [7:0] OFS_BIT_COUNT_LOW = 8'h30;
	localparam logic [7:0] OFS_BIT_SHIFT = 8'h34;
	localparam logic [7:0] OFS_MODE_TWO = 8'h38;
	localparam logic [7:0] OFS_SUBCHAN = 8'h3c;
	localparam logic [7:0] OFS_TS_ADJUST = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h44;

	localparam logic [7:0] RST_MODE_ONE = 8'h00;
	localparam logic [7:0] RST_BIT_COUNT_LOW = 8'hff;
	localparam logic [7:0] RST_BIT_SHIFT = 8'h00;
	localparam logic [7:0] RST_MODE_TWO = 8'h00;
	localparam logic [7:0] RST_SUBCHAN = 8'h00;
	localparam logic [7:0] RST_TS_ADJUST = 8'h02;

	localparam logic [7:0] MASK_BIT_SHIFT = 8'h3f;
	localparam logic [7:0] MASK_TS_ADJUST = 8'h7f;

	// mode one fields
	localparam int CSS_BIT = 7;
	localparam int CMD_LSB = 2;
	localparam logic [1:0] CFI_MODE3 = 2'h3;
	// mode two fields
	localparam int COC_BIT = 4;
	localparam int CXF_BIT = 3;
	localparam int CRR_BIT = 2;
	localparam int CBNH_LSB = 0;
	// bit shift fields
	localparam int CDS_LSB = 3;
	localparam int CUS_LSB = 0;

	localparam logic signed [11:0] SLOT_BIAS = 12'sh002;
	localparam logic signed [11:0] ONE_S12 = 12'sh001;
	localparam logic [2:0] SLOT_LAST_BIT = 3'h7;

	localparam logic [7:0] SLOT_MASK_FULL = 8'hff;
	localparam logic [7:0] SLOT_MASK_HIGH = 8'hf0;
	localparam logic [7:0] SLOT_MASK_LOW = 8'h0f;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [2:0] SHIFT_R2 = 3'h0;
	localparam logic [2:0] SHIFT_R1 = 3'h1;
	localparam logic signed [3:0] LEFT_OF_R2 = -4'sh2;
	localparam logic signed [3:0] LEFT_OF_R1 = -4'sh1;
	localparam logic signed [3:0] LEFT_BASE = 4'sh8;

	// code to left shift in bits; right shifts come out negative
	function automatic logic signed [3:0] tcp_left_bits(input logic [2:0] code);
		logic signed [3:0] r;
		r = LEFT_BASE - $signed({1'b0, code});
		if (code == SHIFT_R2) begin
			r = LEFT_OF_R2;
		end else if (code == SHIFT_R1) begin
			r = LEFT_OF_R1;
		end
		return r;
	endfunction : tcp_left_bits
endpackage : tcp_pkg

// >>> logic/tcp_cfi_port.sv
// configurable tdm port: axi4-lite register bank plus frame and slot timing
//
// Summary of operation
// - frame reference is pcm frame sync when clock source select is 0, else frame sync clock
// - bit-shift codes: 000 two right, 001 one right, 010..111 six..one left
// - both frames shift left by timeslot adjust minus two slots
// - each subchannel field steers one port; in mode 3 also port four higher
// - at 64 kbit/s all eight slot bits are used whatever the field holds
// - at 32 kbit/s field 00/10 uses bits 7..4, 01/11 uses bits 3..0
// - output data changes on rising data clock edge, or falling when bit set
`timescale 1ns/1ps
module tcp_cfi_port
	import tcp_pkg::*;
#(
	parameter int NPORTS = NUM_LINES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [AXI_DATA_W/8-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dataClock,
	input wire logic pcmFrameSync,
	input wire logic frameSyncClock,
	input wire logic [NPORTS-1:0] dataUpstream,
	input wire logic [NPORTS-1:0] rate32k,
	input wire logic [NPORTS-1:0][7:0] txSlotData,
	output logic dataClockOut,
	output logic [NPORTS-1:0] dataDownstream,
	output logic [NPORTS-1:0] dataDownstreamOe,
	output logic [NPORTS-1:0][7:0] rxSlotData,
	output logic [NPORTS-1:0] rxSlotValid,
	output logic [POS_W-1:0] txBitPos,
	output logic [POS_W-1:0] rxBitPos
);
	logic [7:0] modeOneReg;
	logic [7:0] bitLowReg;
	logic [7:0] bitShiftReg;
	logic [7:0] modeTwoReg;
	logic [7:0] subchanReg;
	logic [7:0] tsAdjReg;
	logic [AXI_ADDR_W-1:0] awAddrReg;
	logic [7:0] wDataReg;
	logic wLane0Reg;
	logic awHeldReg;
	logic wHeldReg;

	// pin synchronisers
	logic [NPORTS+2:0] pinSync;
	tcp_sync #(.W(NPORTS + 3)) pinSyncInst (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.asyncIn({frameSyncClock, pcmFrameSync, dataClock, dataUpstream}),
		.syncOut(pinSync)
	);
	wire logic [NPORTS-1:0] upSync = pinSync[NPORTS-1:0];
	wire logic dclSync = pinSync[NPORTS];
	wire logic pfsSync = pinSync[NPORTS+1];
	wire logic fscSync = pinSync[NPORTS+2];

	// register fields
	wire logic clockSourceSel = modeOneReg[CSS_BIT];
	wire logic [1:0] cfiModeField = modeOneReg[CMD_LSB+:2];
	wire logic clockOutCtl = modeTwoReg[COC_BIT];
	wire logic txFalling = modeTwoReg[CXF_BIT];
	wire logic rxRising = modeTwoReg[CRR_BIT];
	wire logic [POS_W-1:0] bitNumber = {1'b0, modeTwoReg[CBNH_LSB+:2], bitLowReg};
	wire logic [2:0] downShift = bitShiftReg[CDS_LSB+:3];
	wire logic [2:0] upShift = bitShiftReg[CUS_LSB+:3];
	wire logic [6:0] tsAdjust = tsAdjReg[6:0];

	// axi write decode
	wire logic doWrite = awHeldReg && wHeldReg && !s_axi_bvalid;
	wire logic wrLane = doWrite && wLane0Reg;
	wire logic wHitOne = awAddrReg == OFS_MODE_ONE;
	wire logic wHitLow = awAddrReg == OFS_BIT_COUNT_LOW;
	wire logic wHitShift = awAddrReg == OFS_BIT_SHIFT;
	wire logic wHitTwo = awAddrReg == OFS_MODE_TWO;
	wire logic wHitSub = awAddrReg == OFS_SUBCHAN;
	wire logic wHitTs = awAddrReg == OFS_TS_ADJUST;
	wire logic wHitStat = awAddrReg == OFS_STATUS;
	wire logic wMapped = wHitOne | wHitLow | wHitShift | wHitTwo | wHitSub | wHitTs | wHitStat;

	// axi read decode
	wire logic arTake = s_axi_arvalid && s_axi_arready;
	wire logic rHitOne = s_axi_araddr == OFS_MODE_ONE;
	wire logic rHitLow = s_axi_araddr == OFS_BIT_COUNT_LOW;
	wire logic rHitShift = s_axi_araddr == OFS_BIT_SHIFT;
	wire logic rHitTwo = s_axi_araddr == OFS_MODE_TWO;
	wire logic rHitSub = s_axi_araddr == OFS_SUBCHAN;
	wire logic rHitTs = s_axi_araddr == OFS_TS_ADJUST;
	wire logic rHitStat = s_axi_araddr == OFS_STATUS;
	wire logic rMapped = rHitOne | rHitLow | rHitShift | rHitTwo | rHitSub | rHitTs | rHitStat;
	wire logic [AXI_DATA_W-1:0] statusWord = {5'h00, rxBitPos, 5'h00, txBitPos};
	wire logic [7:0] rdByte = rHitOne ? modeOneReg :
		rHitLow ? bitLowReg :
		rHitShift ? bitShiftReg :
		rHitTwo ? modeTwoReg :
		rHitSub ? subchanReg :
		rHitTs ? tsAdjReg : 8'h00;
	wire logic [AXI_DATA_W-1:0] rdWord = rHitStat ? statusWord : {24'h000000, rdByte};

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awHeldReg <= 1'b0;
			wHeldReg <= 1'b0;
			awAddrReg <= '0;
			wDataReg <= 8'h00;
			wLane0Reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddrReg <= s_axi_awaddr;
				awHeldReg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wDataReg <= s_axi_wdata[7:0];
				wLane0Reg <= s_axi_wstrb[0];
				wHeldReg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
				awHeldReg <= 1'b0;
				wHeldReg <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (arTake) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdWord;
			s_axi_rresp <= rMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// only byte lane 0 carries the 8-bit registers; status writes are dropped
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			modeOneReg <= RST_MODE_ONE;
			bitLowReg <= RST_BIT_COUNT_LOW;
			bitShiftReg <= RST_BIT_SHIFT;
			modeTwoReg <= RST_MODE_TWO;
			subchanReg <= RST_SUBCHAN;
			tsAdjReg <= RST_TS_ADJUST;
		end else if (wrLane) begin
			if (wHitOne) modeOneReg <= wDataReg;
			if (wHitLow) bitLowReg <= wDataReg;
			if (wHitShift) bitShiftReg <= wDataReg & MASK_BIT_SHIFT;
			if (wHitTwo) modeTwoReg <= wDataReg;
			if (wHitSub) subchanReg <= wDataReg;
			if (wHitTs) tsAdjReg <= wDataReg & MASK_TS_ADJUST;
		end
	end

	// frame reference and data clock edges
	logic dclPrevReg;
	logic refPrevReg;
	logic phaseReg;
	wire logic refLevel = clockSourceSel ? fscSync : pfsSync;
	wire logic refEdge = refLevel && !refPrevReg;
	wire logic dclRise = dclSync && !dclPrevReg;
	// the bit clock is the incoming clock halved; phase marks its high half
	wire logic bitRise = dclRise && !phaseReg;
	wire logic bitFall = dclRise && phaseReg;
	wire logic txTick = txFalling ? bitFall : bitRise;
	wire logic rxTick = rxRising ? bitRise : bitFall;

	// frame start offsets; a start past the frame end is not caught
	wire logic signed [11:0] slotOff = $signed({5'h00, tsAdjust}) - SLOT_BIAS;
	wire logic signed [11:0] downOff = (slotOff <<< SLOT_LOG2) + 12'(tcp_left_bits(downShift));
	wire logic signed [11:0] upOff = (slotOff <<< SLOT_LOG2) + 12'(tcp_left_bits(upShift));
	wire logic signed [11:0] frameLen = $signed({1'b0, bitNumber}) + ONE_S12;
	wire logic [POS_W-1:0] downStart = POS_W'(downOff < 0 ? frameLen + downOff : downOff);
	wire logic [POS_W-1:0] upStart = POS_W'(upOff < 0 ? frameLen + upOff : upOff);
	wire logic [POS_W-1:0] txNext = (txBitPos == bitNumber) ? '0 : txBitPos + 1'b1;
	wire logic [POS_W-1:0] rxNext = (rxBitPos == bitNumber) ? '0 : rxBitPos + 1'b1;
	wire logic [2:0] txBitIdx = ~txBitPos[2:0];
	wire logic rxSlotEnd = rxBitPos[2:0] == SLOT_LAST_BIT;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dclPrevReg <= 1'b0;
			refPrevReg <= 1'b0;
			phaseReg <= 1'b0;
			dataClockOut <= 1'b0;
			txBitPos <= '0;
			rxBitPos <= '0;
		end else begin
			dclPrevReg <= dclSync;
			refPrevReg <= refLevel;
			dataClockOut <= clockOutCtl ? dclSync : phaseReg;
			if (refEdge) begin
				phaseReg <= 1'b0;
				txBitPos <= downStart;
				rxBitPos <= upStart;
			end else begin
				if (dclRise) phaseReg <= !phaseReg;
				if (txTick) txBitPos <= txNext;
				if (rxTick) rxBitPos <= rxNext;
			end
		end
	end

	// per-port slot data path
	genvar p;
	generate
		for (p = 0; p < NPORTS; p++) begin : gPort
			logic [6:0] rxShiftReg;
			wire logic [1:0] subField = subchanReg[2*(p%LOW_LINES)+:2];
			wire logic portOn = (p < LOW_LINES) || (cfiModeField == CFI_MODE3);
			wire logic [7:0] halfMask = subField[0] ? SLOT_MASK_LOW : SLOT_MASK_HIGH;
			wire logic [7:0] slotMask = rate32k[p] ? halfMask : SLOT_MASK_FULL;
			wire logic [7:0] rxByte = {rxShiftReg, upSync[p]};

			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					rxShiftReg <= 7'h00;
					dataDownstream[p] <= 1'b0;
					dataDownstreamOe[p] <= 1'b0;
					rxSlotData[p] <= 8'h00;
					rxSlotValid[p] <= 1'b0;
				end else begin
					rxSlotValid[p] <= 1'b0;
					if (txTick) begin
						dataDownstream[p] <= txSlotData[p][txBitIdx];
						dataDownstreamOe[p] <= portOn && slotMask[txBitIdx];
					end
					if (rxTick) begin
						rxShiftReg <= rxByte[6:0];
						if (rxSlotEnd) begin
							rxSlotData[p] <= rxByte & slotMask;
							rxSlotValid[p] <= portOn;
						end
					end
				end
			end
		end
	endgenerate
endmodule : tcp_cfi_port

// >>> logic/tcp_sync.sv
// two-flop synchroniser for pins arriving from outside mclk
`timescale 1ns/1ps
module tcp_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_reg <= '0;
			syncOut <= '0;
		end else begin
			meta_reg <= asyncIn;
			syncOut <= meta_reg;
		end
	end
endmodule : tcp_sync

// >>> verif/tcp_cfi_port_bench.sv
// self-checking bench for the configurable tdm port
`timescale 1ns/1ps
module tcp_cfi_port_bench
	import tcp_pkg::*;
;
	logic mclk, sys_rst;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic dataClock, pcmFrameSync, frameSyncClock, dataClockOut;
	logic [7:0] dataUpstream, rate32k, dataDownstream, dataDownstreamOe, rxSlotValid;
	logic [7:0][7:0] txSlotData, rxSlotData;
	logic [10:0] txBitPos, rxBitPos;
	logic [7:0] regOfs [6] = '{8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40};
	logic [7:0] regRst [6] = '{8'h00, RST_BIT_COUNT_LOW, 8'h00, 8'h00, 8'h00, RST_TS_ADJUST};
	logic [7:0] regMsk [6] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h7f};
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	tcp_cfi_port u_dut (.*);
	tcp_link_model u_link (.*);
	initial begin
		mclk = 0;
		forever #20 mclk = ~mclk;
	end
	task automatic final_report;
		$display("mismatches %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk("rdata", s_axi_rdata, {24'h000000, ed});
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
		@(posedge mclk);
	endtask : rd
	// reset values, full write, reserved bits, then an unmapped word
	task automatic t_regs;
		for (int i = 0; i < 6; i++) begin
			rd(regOfs[i], regRst[i], RESP_OKAY);
			wr(regOfs[i], 8'hff, RESP_OKAY);
			rd(regOfs[i], regMsk[i], RESP_OKAY);
			wr(regOfs[i], regRst[i], RESP_OKAY);
		end
		wr(8'h48, 8'h55, RESP_SLVERR);
		rd(8'h48, 8'h00, RESP_SLVERR);
	endtask : t_regs
	function automatic int lft(input int c);
		return c < 2 ? c - 2 : 8 - c;
	endfunction : lft
	// every shift code, two frame lengths, both references and both transmit edges
	task automatic t_frame(input logic clock_source_select);
		int len, dp, up;
		for (int i = 0; i < 8; i++) begin
			len = 256 << (i % 2);
			wr(OFS_MODE_ONE, {clock_source_select, 3'h0, i > 3, i > 3, 2'b00}, RESP_OKAY);
			wr(OFS_MODE_TWO, {4'h0, i[1], i[2], 1'b0, i[0]}, RESP_OKAY);
			wr(OFS_TS_ADJUST, 8'(2 + i % 3), RESP_OKAY);
			wr(OFS_BIT_SHIFT, {2'b00, i[2:0], 3'(7 - i)}, RESP_OKAY);
			wr(OFS_SUBCHAN, {4{i[1:0]}}, RESP_OKAY);
			u_link.frame(clock_source_select, 9);
			repeat (6) @(posedge mclk);
			dp = (i % 3 * 8 + lft(i) + len + 9) % len;
			up = (i % 3 * 8 + lft(7 - i) + len + 9) % len;
			chk("txpos", 32'(txBitPos), dp);
			chk("rxpos", 32'(rxBitPos), up);
			chk("dd0", 32'(dataDownstream[0]), 32'(txSlotData[0][7 - (dp - 1) % 8]));
			chk("oe4", 32'(dataDownstreamOe[4]), 32'(i > 3));
			chk("dclout", 32'(dataClockOut), 32'h0);
			u_link.frame(!clock_source_select, 0);
			repeat (6) @(posedge mclk);
			chk("txhold", 32'(txBitPos), dp);
		end
	endtask : t_frame
	initial begin
		sys_rst = 1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		rate32k = 8'h01;
		txSlotData = {8{8'ha6}};
		repeat (5) @(posedge mclk);
		sys_rst <= 0;
		@(posedge mclk);
		t_regs();
		t_frame(1'b0);
		t_frame(1'b1);
		final_report();
	end
endmodule : tcp_cfi_port_bench

// >>> verif/tcp_cfi_port_chk.sv
// concurrent checks on the configurable tdm port
`timescale 1ns/1ps
module tcp_cfi_port_chk
	import tcp_pkg::*;
#(
	parameter int NPORTS = NUM_LINES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NPORTS-1:0] rate32k,
	input wire logic [NPORTS-1:0][7:0] rxSlotData,
	input wire logic [NPORTS-1:0] rxSlotValid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("write not answered");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_rup;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rup: assert property (p_rup) else $error("upper read bits set");
	property p_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_busy: assert property (p_busy) else $error("write taken while busy");
	property p_pulse;
		rxSlotValid[0] |=> !rxSlotValid[0];
	endproperty
	a_pulse: assert property (p_pulse) else $error("slot valid too long");
	// a half slot leaves the other nibble clear
	property p_half;
		rxSlotValid[0] && rate32k[0] |-> rxSlotData[0][7:4] == 4'h0 || rxSlotData[0][3:0] == 4'h0;
	endproperty
	a_half: assert property (p_half) else $error("half slot not masked");
endmodule : tcp_cfi_port_chk

bind tcp_cfi_port tcp_cfi_port_chk #(.NPORTS(NPORTS)) u_chk (.*);

// >>> verif/tcp_link_model.sv
// line-side transceiver: frame references, gated data clock, upstream bits
`timescale 1ns/1ps
module tcp_link_model (
	output logic dataClock,
	output logic pcmFrameSync,
	output logic frameSyncClock,
	output logic [7:0] dataUpstream
);
	initial begin
		dataClock = 0;
		pcmFrameSync = 0;
		frameSyncClock = 0;
		dataUpstream = 8'h5a;
	end
	// clock stands still between frames; data flips on falling edges only
	task automatic frame(input logic useFsc, input int bits);
		if (useFsc) frameSyncClock = 1;
		else pcmFrameSync = 1;
		#400 pcmFrameSync = 0;
		frameSyncClock = 0;
		repeat (2 * bits) begin
			#160 dataClock = 1;
			#160 dataClock = 0;
			dataUpstream = ~dataUpstream;
		end
	endtask : frame
endmodule : tcp_link_model
